// ### blc_cfg_if.sv
// carrier between the register decoder and one storage register
`timescale 1ns/10ps
`default_nettype none
interface blc_cfg_if;
	logic wr_en;
	logic [15:0] wdata;
	logic [15:0] value;
	modport store (input wr_en, input wdata, output value);
	modport user (output wr_en, output wdata, input value);
endinterface
`default_nettype wire

// ### blc_cfg_reg.sv
// one 16-bit read/write configuration register with its reset value
`timescale 1ns/10ps
`default_nettype none
module blc_cfg_reg #(
	parameter logic [15:0] RESET_VALUE = 16'h0000
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// access carrier
	blc_cfg_if.store cfg
);
	logic [15:0] value_ff;

	// all bits stored, reserved ones too, so read-back matches what was written
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			value_ff <= RESET_VALUE;
		end else if (cfg.wr_en) begin
			value_ff <= cfg.wdata;
		end
	end

	assign cfg.value = value_ff;
endmodule
`default_nettype wire

// ### blc_config_regs.sv
// backlight user configuration registers and their decoded controls
`timescale 1ns/10ps
`default_nettype none
module blc_config_regs (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register access port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [15:0] reg_wdata,
	output logic [15:0] reg_rdata_ff,
	output logic reg_rd_valid_ff,
	// boost spread spectrum controls
	output logic spread_pseudo_en_ff,
	output logic [1:0] spread_modulation_rate_ff,
	output logic [19:0] spread_mod_period_cyc_ff,
	output logic [1:0] boost_oscillator_range_ff,
	output logic [6:0] boost_oscillator_spread_pm_ff,
	// brightness source and sloper controls
	output logic bright_from_register_ff,
	output logic bright_source_invalid_ff,
	output logic slope_enable_ff,
	output logic smooth_transition_enable_ff,
	output logic [9:0] slope_duration_ms_ff,
	output logic slope_short_with_smooth_ff,
	// dither controls
	output logic dither_enable_ff,
	output logic [2:0] dither_bits_ff,
	// fault detection controls
	output logic string_ground_short_detect_enable_ff,
	output logic [3:0] string_short_fault_enable_ff,
	output logic test_bits_set_ff
);
	blc_cfg_if bright_if ();
	blc_cfg_if fault_if ();

	logic [15:0] bb;
	logic [15:0] fc;
	logic [10:0] stretched_ms;
	logic [9:0] base_ms;
	logic [2:0] slope_code;
	logic [2:0] dither_code;
	logic [1:0] src_code;
	logic smooth_sel;

	// true when the port address selects the given register
	function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] ofs);
		addr_hit = (addr == ofs);
	endfunction

	// linear slope duration per code
	function automatic logic [9:0] slope_ms(input logic [2:0] code);
		unique case (code)
			3'h0: slope_ms = blc_pkg::SLOPE_MS_0;
			3'h1: slope_ms = blc_pkg::SLOPE_MS_1;
			3'h2: slope_ms = blc_pkg::SLOPE_MS_2;
			3'h3: slope_ms = blc_pkg::SLOPE_MS_3;
			3'h4: slope_ms = blc_pkg::SLOPE_MS_4;
			3'h5: slope_ms = blc_pkg::SLOPE_MS_5;
			3'h6: slope_ms = blc_pkg::SLOPE_MS_6;
			3'h7: slope_ms = blc_pkg::SLOPE_MS_7;
		endcase
	endfunction

	// spread modulation period in clock cycles per rate code
	function automatic logic [19:0] mod_cycles(input logic [1:0] code);
		unique case (code)
			2'h0: mod_cycles = blc_pkg::MOD_CYC_0;
			2'h1: mod_cycles = blc_pkg::MOD_CYC_1;
			2'h2: mod_cycles = blc_pkg::MOD_CYC_2;
			2'h3: mod_cycles = blc_pkg::MOD_CYC_3;
		endcase
	endfunction

	// spread range in tenths of a percent per code
	function automatic logic [6:0] spread_pm(input logic [1:0] code);
		unique case (code)
			2'h0: spread_pm = blc_pkg::SPREAD_PM_0;
			2'h1: spread_pm = blc_pkg::SPREAD_PM_1;
			2'h2: spread_pm = blc_pkg::SPREAD_PM_2;
			2'h3: spread_pm = blc_pkg::SPREAD_PM_3;
		endcase
	endfunction

	// write steering; data goes to both, only the addressed one loads
	assign bright_if.wr_en = reg_wr_en && addr_hit(reg_addr, blc_pkg::BRIGHT_BOOST_OFS);
	assign fault_if.wr_en = reg_wr_en && addr_hit(reg_addr, blc_pkg::FAULT_CFG_OFS);
	assign bright_if.wdata = reg_wdata;
	assign fault_if.wdata = reg_wdata;

	blc_cfg_reg #(
		.RESET_VALUE(blc_pkg::BRIGHT_BOOST_RST)
	) u_bright_boost (
		.clk(clk),
		.rst_b(rst_b),
		.cfg(bright_if)
	);

	blc_cfg_reg #(
		.RESET_VALUE(blc_pkg::FAULT_CFG_RST)
	) u_fault_cfg (
		.clk(clk),
		.rst_b(rst_b),
		.cfg(fault_if)
	);

	assign bb = bright_if.value;
	assign fc = fault_if.value;

	// field extraction from the stored words
	assign slope_code = bb[blc_pkg::SLOPE_LSB +: 3];
	assign dither_code = bb[blc_pkg::DITHER_LSB +: 3];
	assign src_code = bb[blc_pkg::SRC_LSB +: 2];
	assign smooth_sel = bb[blc_pkg::SMOOTH_BIT];
	assign base_ms = slope_ms(slope_code);
	// advanced sloping stretches the time by one half; product widened first, 500 ms overflows 10 bits
	assign stretched_ms = 11'((11'(base_ms) * 11'(blc_pkg::SMOOTH_STRETCH_NUM)) >> 1); // R7

	// read answer one cycle after the strobe; unmapped offsets read zero
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata_ff <= blc_pkg::READ_ZERO;
		end else if (reg_rd_en) begin
			if (addr_hit(reg_addr, blc_pkg::BRIGHT_BOOST_OFS)) begin
				reg_rdata_ff <= bb;
			end else if (addr_hit(reg_addr, blc_pkg::FAULT_CFG_OFS)) begin
				reg_rdata_ff <= fc;
			end else begin
				reg_rdata_ff <= blc_pkg::READ_ZERO;
			end
		end
	end

	// read valid pulse
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rd_valid_ff <= 1'b0;
		end else begin
			reg_rd_valid_ff <= reg_rd_en;
		end
	end

	// boost spread spectrum decode
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			spread_pseudo_en_ff <= blc_pkg::BRIGHT_BOOST_RST[blc_pkg::PSEUDO_BIT];
			spread_modulation_rate_ff <= blc_pkg::BRIGHT_BOOST_RST[blc_pkg::MODRATE_LSB +: 2];
			spread_mod_period_cyc_ff <= blc_pkg::MOD_CYC_0;
			boost_oscillator_range_ff <= blc_pkg::BRIGHT_BOOST_RST[blc_pkg::SPREAD_LSB +: 2];
			boost_oscillator_spread_pm_ff <= blc_pkg::SPREAD_PM_2;
		end else begin
			spread_pseudo_en_ff <= bb[blc_pkg::PSEUDO_BIT]; // R1
			spread_modulation_rate_ff <= bb[blc_pkg::MODRATE_LSB +: 2]; // R2
			spread_mod_period_cyc_ff <= mod_cycles(bb[blc_pkg::MODRATE_LSB +: 2]); // R2
			boost_oscillator_range_ff <= bb[blc_pkg::SPREAD_LSB +: 2]; // R3
			boost_oscillator_spread_pm_ff <= spread_pm(bb[blc_pkg::SPREAD_LSB +: 2]); // R3
		end
	end

	// brightness source; reserved codes fall back to the pin, which is the safe side
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			bright_from_register_ff <= 1'b0;
			bright_source_invalid_ff <= 1'b0;
		end else begin
			bright_from_register_ff <= (src_code == blc_pkg::SRC_BRIGHT_REG); // R4
			bright_source_invalid_ff <= (src_code != blc_pkg::SRC_BRIGHT_REG) &&
				(src_code != blc_pkg::SRC_PWM_PIN); // R5
		end
	end

	// sloper controls; duration shown is the one really applied
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			slope_enable_ff <= 1'b1;
			smooth_transition_enable_ff <= blc_pkg::BRIGHT_BOOST_RST[blc_pkg::SMOOTH_BIT];
			slope_duration_ms_ff <= blc_pkg::SLOPE_MS_0;
			slope_short_with_smooth_ff <= 1'b0;
		end else begin
			slope_enable_ff <= (slope_code != 3'h0); // R6
			smooth_transition_enable_ff <= smooth_sel; // R10
			if (smooth_sel) begin
				slope_duration_ms_ff <= stretched_ms[9:0]; // R7
			end else begin
				slope_duration_ms_ff <= base_ms; // R6
			end
			// flags a setting meant only for linear sloping
			slope_short_with_smooth_ff <= smooth_sel && (slope_code != 3'h0) &&
				(slope_code <= blc_pkg::SLOPE_SHORT_MAX); // R8
		end
	end

	// dither depth; codes above four are undefined and treated as off
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			dither_enable_ff <= 1'b0;
			dither_bits_ff <= blc_pkg::DITHER_OFF;
		end else if (dither_code <= blc_pkg::DITHER_MAX) begin
			dither_enable_ff <= (dither_code != blc_pkg::DITHER_OFF); // R9
			dither_bits_ff <= dither_code; // R9
		end else begin
			dither_enable_ff <= 1'b0;
			dither_bits_ff <= blc_pkg::DITHER_OFF;
		end
	end

	// fault detection controls
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			string_ground_short_detect_enable_ff <= blc_pkg::FAULT_CFG_RST[blc_pkg::GND_DET_BIT];
			test_bits_set_ff <= 1'b0;
		end else begin
			string_ground_short_detect_enable_ff <= fc[blc_pkg::GND_DET_BIT]; // R11
			test_bits_set_ff <= |fc[blc_pkg::TEST_LSB +: 4]; // R12
		end
	end

	// one enable per string, high while that string's short fault is armed
	for (genvar s = 0; s < blc_pkg::STRINGS; s++) begin : g_short
		always_ff @(posedge clk) begin
			if (!rst_b) begin
				string_short_fault_enable_ff[s] <= 1'b1;
			end else begin
				string_short_fault_enable_ff[s] <= !fc[blc_pkg::SHORT_OFF_LSB + s]; // R13
			end
		end
	end
endmodule
`default_nettype wire

// ### blc_config_regs_monitor.sv
// checker for the backlight configuration registers
`timescale 1ns/10ps
`default_nettype none
module blc_config_regs_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic reg_wr_en,
	input wire logic reg_rd_en,
	input wire logic [15:0] reg_wdata,
	input wire logic [15:0] reg_rdata_ff,
	input wire logic reg_rd_valid_ff,
	// decoded controls
	input wire logic spread_pseudo_en_ff,
	input wire logic [19:0] spread_mod_period_cyc_ff,
	input wire logic [6:0] boost_oscillator_spread_pm_ff,
	input wire logic bright_from_register_ff,
	input wire logic [9:0] slope_duration_ms_ff,
	input wire logic [2:0] dither_bits_ff,
	input wire logic string_ground_short_detect_enable_ff,
	input wire logic [3:0] string_short_fault_enable_ff
);
	localparam logic [19:0] PER [4] = '{20'h7a120, 20'h30d40, 20'h1e848, 20'h14585};
	localparam logic [6:0] PM [4] = '{7'h21, 7'h2b, 7'h35, 7'h48};
	localparam logic [9:0] MS [8] = '{10'h000, 10'h001, 10'h002, 10'h032,
		10'h064, 10'h0c8, 10'h12c, 10'h1f4};
	logic [15:0] sh1_ff;
	logic [15:0] sh2_ff;
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	// shadow copies, so every read is judged against what was stored
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			sh1_ff <= 16'h08a3;
			sh2_ff <= 16'h0100;
		end else if (reg_wr_en && reg_addr == 8'h04) begin
			sh1_ff <= reg_wdata;
		end else if (reg_wr_en && reg_addr == 8'h06) begin
			sh2_ff <= reg_wdata;
		end
	end
	// a write taken by each register; decode lands two edges on
	sequence s_wr1;
		reg_wr_en && reg_addr == 8'h04;
	endsequence
	sequence s_wr2;
		reg_wr_en && reg_addr == 8'h06;
	endsequence
	a_pseudo_follows_write: assert property (s_wr1 |=> ##1
		spread_pseudo_en_ff == $past(reg_wdata[14], 2)) else $error("pseudo enable wrong");
	a_mod_period_map: assert property (s_wr1 |=> ##1
		spread_mod_period_cyc_ff == PER[$past(reg_wdata[13:12], 2)]) else $error("period wrong");
	a_spread_pm_map: assert property (s_wr1 |=> ##1
		boost_oscillator_spread_pm_ff == PM[$past(reg_wdata[11:10], 2)]) else $error("spread wrong");
	a_source_select: assert property (s_wr1 |=> ##1
		bright_from_register_ff == ($past(reg_wdata[9:8], 2) == 2'h2)) else $error("source wrong");
	a_slope_duration_map: assert property (s_wr1 |=> ##1 slope_duration_ms_ff ==
		($past(reg_wdata[1], 2) ? 10'((MS[$past(reg_wdata[7:5], 2)] * 3) >> 1)
		: MS[$past(reg_wdata[7:5], 2)])) else $error("slope duration wrong");
	a_dither_depth: assert property (s_wr1 |=> ##1 dither_bits_ff ==
		($past(reg_wdata[4:2], 2) > 3'h4 ? 3'h0 : $past(reg_wdata[4:2], 2)))
		else $error("dither depth wrong");
	a_fault_cfg_write: assert property (s_wr2 |=> ##1
		string_ground_short_detect_enable_ff == $past(reg_wdata[8], 2) &&
		string_short_fault_enable_ff == ~$past(reg_wdata[3:0], 2)) else $error("fault cfg wrong");
	a_read_matches_store: assert property (reg_rd_en |=> reg_rd_valid_ff &&
		reg_rdata_ff == ($past(reg_addr) == 8'h04 ? $past(sh1_ff) :
		$past(reg_addr) == 8'h06 ? $past(sh2_ff) : 16'h0000)) else $error("read data wrong");
endmodule
bind blc_config_regs blc_config_regs_monitor mon (.clk, .rst_b, .reg_addr, .reg_wr_en,
	.reg_rd_en, .reg_wdata, .reg_rdata_ff, .reg_rd_valid_ff, .spread_pseudo_en_ff,
	.spread_mod_period_cyc_ff, .boost_oscillator_spread_pm_ff, .bright_from_register_ff,
	.slope_duration_ms_ff, .dither_bits_ff, .string_ground_short_detect_enable_ff,
	.string_short_fault_enable_ff);
`default_nettype wire

// ### blc_pkg.sv
// constants and field layout of the backlight user configuration registers
// Contract
// (R1) bit 14 enables pseudo-random spread modulation
// (R2) bits 13-12 pick spread modulation rate
// (R3) bits 11-10 pick boost spread range
// (R4) bits 9-8 pick brightness source
// (R5) host never writes source codes 1, 3
// (R6) bits 7-5 set slope duration, reset 5
// (R7) advanced sloping lengthens and smooths transitions
// (R8) host uses 1/2 ms only when linear
// (R9) bits 4-2 set dither depth 0..4
// (R10) bit 1 picks linear or advanced sloping
// (R11) second register bit 8 enables ground-short detect
// (R12) host writes zero to bits 7-4
// (R13) bits 3-0 suppress string short faults
// (R14) host preserves reserved bits by read-modify-write
`default_nettype none
package blc_pkg;
	localparam int unsigned REG_W = 16;
	localparam int unsigned ADDR_W = 8;
	// register offsets and reset values
	localparam logic [7:0] BRIGHT_BOOST_OFS = 8'h04;
	localparam logic [7:0] FAULT_CFG_OFS = 8'h06;
	localparam logic [15:0] BRIGHT_BOOST_RST = 16'h08a3;
	localparam logic [15:0] FAULT_CFG_RST = 16'h0100;
	localparam logic [15:0] READ_ZERO = 16'h0000;
	// first register field positions
	localparam int unsigned PSEUDO_BIT = 14;
	localparam int unsigned MODRATE_LSB = 12;
	localparam int unsigned SPREAD_LSB = 10;
	localparam int unsigned SRC_LSB = 8;
	localparam int unsigned SLOPE_LSB = 5;
	localparam int unsigned DITHER_LSB = 2;
	localparam int unsigned SMOOTH_BIT = 1;
	// second register field positions
	localparam int unsigned GND_DET_BIT = 8;
	localparam int unsigned TEST_LSB = 4;
	localparam int unsigned SHORT_OFF_LSB = 0;
	localparam int unsigned STRINGS = 4;
	// brightness source codes
	localparam logic [1:0] SRC_PWM_PIN = 2'h0;
	localparam logic [1:0] SRC_BRIGHT_REG = 2'h2;
	// dither
	localparam logic [2:0] DITHER_MAX = 3'h4;
	localparam logic [2:0] DITHER_OFF = 3'h0;
	// clock and spread modulation rates in Hz
	localparam int unsigned CLK_HZ = 100_000_000;
	localparam int unsigned MOD_HZ_0 = 200;
	localparam int unsigned MOD_HZ_1 = 500;
	localparam int unsigned MOD_HZ_2 = 800;
	localparam int unsigned MOD_HZ_3 = 1200;
	localparam int unsigned MOD_CYC_W = 20;
	localparam logic [19:0] MOD_CYC_0 = 20'(CLK_HZ / MOD_HZ_0);
	localparam logic [19:0] MOD_CYC_1 = 20'(CLK_HZ / MOD_HZ_1);
	localparam logic [19:0] MOD_CYC_2 = 20'(CLK_HZ / MOD_HZ_2);
	localparam logic [19:0] MOD_CYC_3 = 20'(CLK_HZ / MOD_HZ_3);
	// spread ranges in tenths of a percent
	localparam logic [6:0] SPREAD_PM_0 = 7'd33;
	localparam logic [6:0] SPREAD_PM_1 = 7'd43;
	localparam logic [6:0] SPREAD_PM_2 = 7'd53;
	localparam logic [6:0] SPREAD_PM_3 = 7'd72;
	// slope durations in ms, linear mode
	localparam logic [9:0] SLOPE_MS_0 = 10'd0;
	localparam logic [9:0] SLOPE_MS_1 = 10'd1;
	localparam logic [9:0] SLOPE_MS_2 = 10'd2;
	localparam logic [9:0] SLOPE_MS_3 = 10'd50;
	localparam logic [9:0] SLOPE_MS_4 = 10'd100;
	localparam logic [9:0] SLOPE_MS_5 = 10'd200;
	localparam logic [9:0] SLOPE_MS_6 = 10'd300;
	localparam logic [9:0] SLOPE_MS_7 = 10'd500;
	// advanced sloping stretch factor, numerator over two
	localparam logic [1:0] SMOOTH_STRETCH_NUM = 2'h3;
	localparam logic [2:0] SLOPE_SHORT_MAX = 3'h2;
endpackage
`default_nettype wire

// ### tb_backlight_user_config_regs.sv
// self-checking bench for the backlight configuration registers
`timescale 1ns/10ps
`default_nettype none
module tb_backlight_user_config_regs;
	logic clk, rst_b, reg_wr_en, reg_rd_en, reg_rd_valid_ff, spread_pseudo_en_ff;
	logic bright_from_register_ff, bright_source_invalid_ff, slope_enable_ff;
	logic smooth_transition_enable_ff, slope_short_with_smooth_ff, dither_enable_ff;
	logic string_ground_short_detect_enable_ff, test_bits_set_ff;
	logic [1:0] spread_modulation_rate_ff, boost_oscillator_range_ff;
	logic [2:0] dither_bits_ff;
	logic [3:0] string_short_fault_enable_ff;
	logic [6:0] boost_oscillator_spread_pm_ff;
	logic [7:0] reg_addr;
	logic [9:0] slope_duration_ms_ff;
	logic [15:0] reg_wdata, reg_rdata_ff, rv;
	logic [19:0] spread_mod_period_cyc_ff;
	logic [19:0] per [4] = '{20'h7a120, 20'h30d40, 20'h1e848, 20'h14585};
	logic [6:0] pm [4] = '{7'h21, 7'h2b, 7'h35, 7'h48};
	logic [9:0] ms [8] = '{10'h000, 10'h001, 10'h002, 10'h032, 10'h064, 10'h0c8, 10'h12c, 10'h1f4};
	int n_errors = 0;
	int cmp_count = 0;
	blc_config_regs dut (.*);
	// verdict, also reached when a wait runs out
	task automatic test_done();
		if (n_errors == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input logic [19:0] g, input logic [19:0] e);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	// write pulse, then wait until the decode has landed
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr_en <= 1'b1;
		@(posedge clk);
		reg_wr_en <= 1'b0;
		repeat (2) @(posedge clk);
		#1;
	endtask
	// read pulse; the valid flag is polled for a bounded time
	task automatic rd(input logic [7:0] a, output logic [15:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd_en <= 1'b1;
		for (int k = 0; k < 4; k++) begin
			@(posedge clk);
			reg_rd_en <= 1'b0;
			#1;
			if (reg_rd_valid_ff === 1'b1) begin
				chk(20'(k), 20'h0);
				d = reg_rdata_ff;
				return;
			end
		end
		n_errors++;
		test_done();
	endtask
	task automatic t_reset();
		rd(8'h04, rv);
		chk(20'(rv), 20'h008a3);
		rd(8'h06, rv);
		chk(20'(rv), 20'h00100);
		chk(20'(spread_pseudo_en_ff), 20'h0);
		chk(spread_mod_period_cyc_ff, per[0]);
		chk(20'(boost_oscillator_spread_pm_ff), 20'h00035);
		chk(20'(slope_duration_ms_ff), 20'h0012c);
		chk(20'(string_short_fault_enable_ff), 20'h0000f);
		chk(20'(spread_modulation_rate_ff), 20'h0);
		chk(20'(boost_oscillator_range_ff), 20'h2);
		chk(20'(bright_from_register_ff), 20'h0);
		chk(20'(slope_enable_ff), 20'h1);
		chk(20'(smooth_transition_enable_ff), 20'h1);
		chk(20'(dither_bits_ff), 20'h0);
		chk(20'(string_ground_short_detect_enable_ff), 20'h1);
	endtask
	// every code of each field except source codes 1 and 3, both sloping styles
	task automatic t_first();
		logic [15:0] d;
		logic [2:0] i;
		for (int k = 0; k < 8; k++) begin
			i = 3'(k);
			d = {1'b0, i[0], i[1:0], i[2:1], i[0], 1'b0, i, i, i[2], 1'b1};
			wr(8'h04, d);
			chk(20'(spread_modulation_rate_ff), 20'(i[1:0]));
			chk(20'(boost_oscillator_range_ff), 20'(i[2:1]));
			chk(20'(bright_source_invalid_ff), 20'h0);
			chk(20'(slope_enable_ff), 20'(i != 3'h0));
			chk(20'(smooth_transition_enable_ff), 20'(d[1]));
			chk(20'(slope_short_with_smooth_ff), 20'h0);
			chk(20'(dither_enable_ff), 20'(i != 3'h0 && i <= 3'h4));
			chk(20'(spread_pseudo_en_ff), 20'(i[0]));
			chk(spread_mod_period_cyc_ff, per[i[1:0]]);
			chk(20'(boost_oscillator_spread_pm_ff), 20'(pm[i[2:1]]));
			chk(20'(bright_from_register_ff), 20'(i[0]));
			chk(20'(slope_duration_ms_ff), 20'(d[1] ? (ms[i] * 3) >> 1 : ms[i]));
			chk(20'(dither_bits_ff), 20'(i > 3'h4 ? 3'h0 : i));
			rd(8'h04, rv);
			chk(20'(rv), 20'(d));
		end
	endtask
	// one string at a time, then a foreign offset
	task automatic t_second();
		logic [3:0] m;
		for (int k = 0; k < 4; k++) begin
			wr(8'h06, {7'h00, k[0], 4'h0, 4'h1 << k});
			m = ~(4'h1 << k);
			chk(20'(test_bits_set_ff), 20'h0);
			chk(20'(string_ground_short_detect_enable_ff), 20'(k[0]));
			chk(20'(string_short_fault_enable_ff), 20'(m));
		end
		wr(8'h05, 16'hffff);
		rd(8'h06, rv);
		chk(20'(rv), 20'h00108);
		rd(8'h08, rv);
		chk(20'(rv), 20'h00000);
	endtask
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		rst_b = 1'b0;
		reg_addr = 8'h00;
		reg_wr_en = 1'b0;
		reg_rd_en = 1'b0;
		reg_wdata = 16'h0000;
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		t_reset();
		t_first();
		t_second();
		test_done();
	end
endmodule
`default_nettype wire
